/* pkg/sdram_ctl_pkg.sv */
/*
 * Constants for the host-side SDRAM command, refresh and power controller.
 * Assumes a 40 MHz ref_clk; the SDRAM clock is ref_clk divided by two.
 */
package sdram_ctl_pkg;

  // Software register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h04;
  localparam logic [7:0] REG_CMD = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_REFCNT = 8'h10;

  // CTRL fields
  localparam int CTRL_PD_BIT = 0;
  localparam int CTRL_SR_BIT = 1;
  localparam int CTRL_DQM_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h4;

  // MODE fields
  localparam int MODE_WBS_BIT = 9;
  localparam int MODE_ADDR_TEN_BIT = 10;
  localparam logic [11:0] MODE_RESET = 12'h020;

  // CMD register codes
  localparam logic [1:0] SWCMD_MRS = 2'h1;
  localparam logic [1:0] SWCMD_STOP = 2'h2;
  localparam logic [1:0] SWCMD_REFBURST = 2'h3;

  // Pin command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] PIN_NOP = 4'h7;
  localparam logic [3:0] PIN_DESEL = 4'hF;
  localparam logic [3:0] PIN_REFRESH = 4'h1;
  localparam logic [3:0] PIN_MRS = 4'h0;
  localparam logic [3:0] PIN_STOP = 4'h6;

  // Times
  localparam int CLK_PS = 25000;
  localparam int LINK_PS = 2 * CLK_PS;
  localparam int REFRESH_PERIOD_NS = 64000000;
  localparam int REFRESH_COUNT = 4096;
  localparam int ROW_CYCLE_PS = 63000;
  localparam int PRECHARGE_PS = 21000;
  localparam int MODE_SET_PS = 14000;
  localparam int SELF_REFRESH_EXIT_PS = 70000;
  localparam int POWERDOWN_EXIT_SETUP_PS = 8500;

  function automatic int ticks_min(input int ps);
    int t;
    t = (ps + LINK_PS - 1) / LINK_PS;
    return (t < 1) ? 1 : t;
  endfunction : ticks_min

  // Link clock periods
  localparam int REFRESH_GAP_TK =
    (REFRESH_PERIOD_NS / REFRESH_COUNT) * 1000 / LINK_PS;
  localparam int REF_WAIT_TK =
    ticks_min(ROW_CYCLE_PS) + ticks_min(PRECHARGE_PS);
  localparam int MRS_WAIT_TK = ticks_min(MODE_SET_PS);
  localparam int XSR_WAIT_TK = ticks_min(SELF_REFRESH_EXIT_PS);
  localparam int PDX_WAIT_TK = ticks_min(POWERDOWN_EXIT_SETUP_PS) + 1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PD = 4'h2,
    ST_SR = 4'h4,
    ST_SRX = 4'h8
  } ctl_state_t;

endpackage : sdram_ctl_pkg

/* pkg/link_clk_if.sv */
/*
 * Link clock bundle between the divider and the controller.
 * Assumes both ends run on ref_clk.
 */
`timescale 1ns/1ps
interface link_clk_if;
  logic run;
  logic tick;
  logic clk_out;
  modport gen (input run, output tick, output clk_out);
  modport ctl (output run, input tick, input clk_out);
endinterface : link_clk_if

/* rtl/link_clk_gen.sv */
/*
 * Divide-by-two SDRAM clock with stop control.
 * Assumes run comes from logic on ref_clk; tick marks the falling edge.
 */
`timescale 1ns/1ps
module link_clk_gen (
  input wire logic ref_clk,
  input wire logic rstn,
  link_clk_if.gen lk
);
  logic phase_r;
  logic clk_r;

  // Phase runs always so command timing continues with the clock stopped
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
    end
  end

  // Clock stops low; restarts only on a rising phase
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clk_r <= 1'b0;
    end else begin
      clk_r <= ~phase_r & lk.run;
    end
  end

  assign lk.tick = phase_r;
  assign lk.clk_out = clk_r;

  phase_alt_a: assert property (@(posedge ref_clk) disable iff (!rstn)
    phase_r |=> !phase_r)
    else $error("Tick not alternating");
endmodule : link_clk_gen

/* rtl/sdram_ctl.sv */
/*
 * Host controller for SDRAM command, refresh and power modes.
 * Assumes software on ref_clk; the SDRAM samples pins on sdram_clk rise.
 */
// Functional notes
// (RULE1) Mode bit 9 zero bursts writes; one makes writes single-word.
// (RULE2) Mode register set holds address bit ten and bank selects low.
// (RULE3) Select low with strobes and write enable high is no-operation.
// (RULE4) Burst stop encoding ends a burst lacking auto precharge.
// (RULE5) Stopped read data ends after the CAS latency.
// (RULE6) Select high makes the device ignore command and address pins.
// (RULE7) Auto refresh uses an internal row counter, address ignored.
// (RULE8) 4096 auto refreshes per 64 ms, each issued anew.
// (RULE9) Auto refresh only with banks idle and clock enable high before.
// (RULE10) After auto refresh only no-operations until row cycle time.
// (RULE11) Precharge time met before the next refresh in a series.
// (RULE12) Self refresh: refresh encoding, clock enable low for the stay.
// (RULE13) Self refresh exit: restart clock, raise enable, then waits.
// (RULE14) Burst of 4096 refreshes before and after self refresh.
// (RULE15) Clock enable low in a burst suspends the device clock.
// (RULE16) Clock enable low with banks idle enters power-down.
// (RULE17) Suspend or power-down never longer than the refresh period.
// (RULE18) Exit cycle of clock enable rise carries a no-operation.
// (RULE19) New command one cycle after exit, plus power-down setup.
// (RULE20) Data mask high skips that write word.
// (RULE21) Data mask high disables read outputs.
// (RULE22) Read output disable follows data mask by two clocks.
`timescale 1ns/1ps
module sdram_ctl #(
  parameter int REFRESH_BURST = sdram_ctl_pkg::REFRESH_COUNT,
  parameter int REFRESH_GAP = sdram_ctl_pkg::REFRESH_GAP_TK
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic sdram_clk,
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [11:0] addr,
  output logic [1:0] bank_sel,
  output logic dqm
);
  import sdram_ctl_pkg::*;

  if (REFRESH_BURST < 1 || REFRESH_BURST > 65535) begin : g_chk_burst
    $error("REFRESH_BURST out of range");
  end
  if (REFRESH_GAP < 2 || REFRESH_GAP > 65535) begin : g_chk_gap
    $error("REFRESH_GAP out of range");
  end

  localparam logic [15:0] BURST_N = 16'(REFRESH_BURST);
  localparam logic [15:0] GAP_LAST = 16'(REFRESH_GAP - 1);

  link_clk_if lk ();

  link_clk_gen u_clk (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .lk(lk)
  );

  logic tick;
  assign tick = lk.tick;
  assign sdram_clk = lk.clk_out;

  // Software state
  logic [2:0] ctrl_r;
  logic [11:0] mode_r;
  logic mrs_pend_r;
  logic stop_pend_r;
  logic refb_pend_r;
  logic [31:0] rdata_r;

  // Sequencer state
  ctl_state_t state_r, state_nxt;
  logic [3:0] pin_r, pin_nxt;
  logic cke_r, cke_nxt;
  logic run_r, run_nxt;
  logic [11:0] addr_r, addr_nxt;
  logic [15:0] wait_r, wait_nxt;
  logic [15:0] burst_r, burst_nxt;
  logic sr_ready_r, sr_ready_nxt;
  logic [15:0] gap_r;
  logic due_r;
  logic [15:0] refcnt_r;
  logic take_mrs, take_stop, take_refb, ref_issue;

  function automatic logic sw_hit(input logic [7:0] off);
    return sw_wr && sw_addr == off;
  endfunction : sw_hit

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r <= CTRL_RESET;
      mode_r <= MODE_RESET;
    end else begin
      if (sw_hit(REG_CTRL)) begin
        ctrl_r <= sw_wdata[2:0];
      end
      if (sw_hit(REG_MODE)) begin
        mode_r <= sw_wdata[11:0]; // see RULE1
      end
    end
  end

  // Requests wait for the sequencer; a new write wins over acceptance
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mrs_pend_r <= 1'b0;
      stop_pend_r <= 1'b0;
      refb_pend_r <= 1'b0;
    end else begin
      mrs_pend_r <= (sw_hit(REG_CMD) && sw_wdata[1:0] == SWCMD_MRS) ||
        (mrs_pend_r && !take_mrs);
      stop_pend_r <= (sw_hit(REG_CMD) && sw_wdata[1:0] == SWCMD_STOP) ||
        (stop_pend_r && !take_stop);
      refb_pend_r <= (sw_hit(REG_CMD) && sw_wdata[1:0] == SWCMD_REFBURST) ||
        (refb_pend_r && !take_refb);
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= 32'h0000_0000;
      if (sw_rd) begin
        case (sw_addr)
          REG_CTRL: rdata_r <= {29'h0000_0000, ctrl_r};
          REG_MODE: rdata_r <= {20'h0_0000, mode_r};
          REG_STATUS: rdata_r <= {16'h0000, burst_r != 16'h0000, due_r,
            cke_r, run_r, 8'h00, state_r};
          REG_REFCNT: rdata_r <= {16'h0000, refcnt_r};
          default: rdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign sw_rdata = rdata_r;

  // Command sequencer, advanced once per link clock
  always_comb begin
    state_nxt = state_r;
    pin_nxt = PIN_NOP; // see RULE3
    cke_nxt = 1'b1;
    run_nxt = 1'b1;
    addr_nxt = 12'h000;
    wait_nxt = (wait_r != 16'h0000) ? wait_r - 16'h0001 : 16'h0000;
    burst_nxt = burst_r;
    // A withdrawn self refresh request must not skip the next burst
    sr_ready_nxt = sr_ready_r && ctrl_r[CTRL_SR_BIT];
    take_mrs = 1'b0;
    take_stop = 1'b0;
    take_refb = 1'b0;
    ref_issue = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (wait_r != 16'h0000) begin
          pin_nxt = PIN_NOP; // see RULE10
        end else if (due_r || burst_r != 16'h0000) begin
          // Only idle banks and a high enable reach here; see RULE9
          pin_nxt = PIN_REFRESH; // see RULE7
          ref_issue = 1'b1;
          wait_nxt = 16'(REF_WAIT_TK); // see RULE10 see RULE11
          if (burst_r != 16'h0000) begin
            burst_nxt = burst_r - 16'h0001;
          end
        end else if (mrs_pend_r) begin
          pin_nxt = PIN_MRS;
          addr_nxt = mode_r;
          addr_nxt[MODE_ADDR_TEN_BIT] = 1'b0; // see RULE2
          take_mrs = 1'b1;
          wait_nxt = 16'(MRS_WAIT_TK);
        end else if (stop_pend_r) begin
          pin_nxt = PIN_STOP; // see RULE4
          take_stop = 1'b1;
        end else if (refb_pend_r) begin
          burst_nxt = BURST_N;
          take_refb = 1'b1;
        end else if (ctrl_r[CTRL_SR_BIT]) begin
          if (sr_ready_r) begin
            pin_nxt = PIN_REFRESH; // see RULE12
            cke_nxt = 1'b0;
            sr_ready_nxt = 1'b0;
            state_nxt = ST_SR;
          end else begin
            burst_nxt = BURST_N; // see RULE14
            sr_ready_nxt = 1'b1;
          end
        end else if (ctrl_r[CTRL_PD_BIT]) begin
          cke_nxt = 1'b0; // see RULE16
          state_nxt = ST_PD;
        end
      end
      ST_PD: begin
        cke_nxt = 1'b0;
        // Leave early when a refresh falls due; see RULE17
        if (!ctrl_r[CTRL_PD_BIT] || due_r) begin
          cke_nxt = 1'b1; // see RULE18
          wait_nxt = 16'(PDX_WAIT_TK); // see RULE19
          state_nxt = ST_IDLE;
        end
      end
      ST_SR: begin
        cke_nxt = 1'b0; // see RULE12
        run_nxt = 1'b0;
        if (!ctrl_r[CTRL_SR_BIT]) begin
          run_nxt = 1'b1; // see RULE13
          state_nxt = ST_SRX;
        end
      end
      ST_SRX: begin
        cke_nxt = 1'b1; // see RULE13
        wait_nxt = 16'(XSR_WAIT_TK);
        burst_nxt = BURST_N; // see RULE14
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!tick) begin
      state_nxt = state_r;
      pin_nxt = pin_r;
      cke_nxt = cke_r;
      run_nxt = run_r;
      addr_nxt = addr_r;
      wait_nxt = wait_r;
      burst_nxt = burst_r;
      sr_ready_nxt = sr_ready_r;
      take_mrs = 1'b0;
      take_stop = 1'b0;
      take_refb = 1'b0;
      ref_issue = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= ST_IDLE;
      pin_r <= PIN_DESEL;
      cke_r <= 1'b1;
      run_r <= 1'b1;
      addr_r <= 12'h000;
      wait_r <= 16'h0000;
      burst_r <= 16'h0000;
      sr_ready_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pin_r <= pin_nxt;
      cke_r <= cke_nxt;
      run_r <= run_nxt;
      addr_r <= addr_nxt;
      wait_r <= wait_nxt;
      burst_r <= burst_nxt;
      sr_ready_r <= sr_ready_nxt;
    end
  end

  // Refresh spacing timer; a new due wins over the clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gap_r <= 16'h0000;
      due_r <= 1'b0;
      refcnt_r <= 16'h0000;
    end else begin
      if (ref_issue) begin
        refcnt_r <= refcnt_r + 16'h0001;
      end
      if (state_r == ST_SR || ref_issue) begin
        gap_r <= 16'h0000;
      end else if (tick) begin
        gap_r <= (gap_r >= GAP_LAST) ? 16'h0000 : gap_r + 16'h0001;
      end
      if (tick && state_r != ST_SR && gap_r >= GAP_LAST) begin
        due_r <= 1'b1; // see RULE8
      end else if (state_r == ST_SR || ref_issue) begin
        due_r <= 1'b0;
      end
    end
  end

  assign lk.run = run_r;
  assign cke = cke_r;
  assign {cs_n, ras_n, cas_n, we_n} = pin_r;
  assign addr = addr_r;
  assign bank_sel = 2'h0; // see RULE2
  assign dqm = ctrl_r[CTRL_DQM_BIT]; // see RULE21

  // Ticks since the last refresh outside self refresh
  logic [15:0] since_r;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      since_r <= 16'h0000;
    end else if (state_r == ST_SR || ref_issue) begin
      since_r <= 16'h0000;
    end else if (tick && since_r != 16'hFFFF) begin
      since_r <= since_r + 16'h0001;
    end
  end

  mrs_addr_a: assert property (@(posedge ref_clk) // see RULE2
    disable iff (!rstn)
    pin_r == PIN_MRS |-> !addr_r[MODE_ADDR_TEN_BIT] && bank_sel == 2'h0)
    else $error("Mode set with address bit ten or bank high");

  ref_nop_a: assert property (@(posedge ref_clk) // see RULE10
    disable iff (!rstn)
    tick && pin_nxt == PIN_REFRESH && cke_nxt |=> ##2 pin_r == PIN_NOP)
    else $error("Command right after auto refresh");

  ref_cke_a: assert property (@(posedge ref_clk) // see RULE9
    disable iff (!rstn)
    $changed(pin_r) && pin_r == PIN_REFRESH && cke_r |-> $past(cke_r, 2))
    else $error("Auto refresh after low clock enable");

  sr_cke_a: assert property (@(posedge ref_clk) // see RULE12
    disable iff (!rstn)
    state_r == ST_SR |-> !cke_r)
    else $error("Clock enable high in self refresh");

  exit_nop_a: assert property (@(posedge ref_clk) // see RULE18
    disable iff (!rstn)
    $rose(cke_r) |-> pin_r == PIN_NOP || pin_r == PIN_DESEL)
    else $error("Command with clock enable rise");

  exit_gap_a: assert property (@(posedge ref_clk) // see RULE19
    disable iff (!rstn)
    $rose(cke_r) |-> (pin_r == PIN_NOP)[*4])
    else $error("Command too soon after exit");

  sr_restart_a: assert property (@(posedge ref_clk) // see RULE13
    disable iff (!rstn)
    $rose(cke_r) && $past(state_r) == ST_SRX |-> $past(run_r, 2))
    else $error("Clock enable raised before clock restart");

  refresh_gap_a: assert property (@(posedge ref_clk) // see RULE8
    disable iff (!rstn)
    since_r <= 16'(REFRESH_GAP + REF_WAIT_TK + XSR_WAIT_TK + 4))
    else $error("Refresh interval exceeded");

  stop_issue_a: assert property (@(posedge ref_clk) // see RULE4
    disable iff (!rstn)
    take_stop |=> pin_r == PIN_STOP && cke_r)
    else $error("Burst stop not driven");

  pd_due_a: assert property (@(posedge ref_clk) // see RULE17
    disable iff (!rstn)
    state_r == ST_PD && due_r |-> ##[1:3] state_r == ST_IDLE)
    else $error("Power-down held past refresh due");
endmodule : sdram_ctl

/* verification/sdram_dev_model.sv */
/*
 * Behavioural SDRAM device: refresh, mode set, burst stop, power modes.
 * Assumes pins settle before each sdram_clk rise; all banks stay idle.
 */
`timescale 1ns/1ps
module sdram_dev_model #(
  parameter int BUSY_TK = 2
) (
  input wire logic sdram_clk,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [1:0] bank_sel,
  input wire logic dqm,
  output logic [15:0] ref_cnt,
  output logic [11:0] mode_reg,
  output logic [7:0] stop_cnt,
  output logic in_sr,
  output logic in_pd,
  output logic [7:0] err_cnt,
  output logic out_en
);
  logic prev_cke = 1'b1;
  logic [1:0] dqm_pipe = 2'b11;
  logic [2:0] op;
  int busy = 0;

  initial begin
    ref_cnt = 16'h0000;
    mode_reg = 12'hFFF;
    stop_cnt = 8'h00;
    in_sr = 1'b0;
    in_pd = 1'b0;
    err_cnt = 8'h00;
  end

  assign op = {ras_n, cas_n, we_n};
  // Read output buffers follow the mask two clocks late
  assign out_en = ~dqm_pipe[1];

  always @(posedge sdram_clk) begin
    prev_cke <= cke;
    dqm_pipe <= {dqm_pipe[0], dqm};
    if (busy > 0) begin
      busy <= busy - 1;
    end
    if (in_sr) begin
      // Only clock enable matters until exit
      if (cke) begin
        in_sr <= 1'b0;
        busy <= BUSY_TK;
        if (!cs_n && op != 3'b111) begin
          err_cnt <= err_cnt + 8'h01;
        end
      end
    end else if (in_pd) begin
      if (cke) begin
        in_pd <= 1'b0;
        busy <= 1;
        if (!cs_n && op != 3'b111) begin
          err_cnt <= err_cnt + 8'h01;
        end
      end
    end else if (!prev_cke) begin
      // Internal clock masked: nothing registered
    end else if (!cs_n) begin
      if (busy > 0 && op != 3'b111) begin
        err_cnt <= err_cnt + 8'h01;
      end
      case (op)
        3'b001: begin
          if (cke) begin
            ref_cnt <= ref_cnt + 16'h0001;
            busy <= BUSY_TK;
          end else begin
            in_sr <= 1'b1;
          end
        end
        3'b000: begin
          mode_reg <= addr;
          if (addr[10] || bank_sel != 2'h0) begin
            err_cnt <= err_cnt + 8'h01;
          end
        end
        3'b110: stop_cnt <= stop_cnt + 8'h01;
        default: ;
      endcase
      if (!cke && op != 3'b001) begin
        in_pd <= 1'b1;
      end
    end else if (!cke) begin
      in_pd <= 1'b1;
    end
  end
endmodule : sdram_dev_model

/* verification/tb.sv */
/*
 * Self-checking bench for the SDRAM command, refresh and power controller.
 * Assumes sdram_ctl, its package and the device model are compiled first.
 */
`timescale 1ns/1ps
module tb;
  import sdram_ctl_pkg::*;
  localparam int BURST = 4;
  localparam int GAP = 20;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic sdram_clk, cke, cs_n, ras_n, cas_n, we_n, dqm, in_sr, in_pd, out_en;
  logic [11:0] addr;
  logic [11:0] mode_reg;
  logic [1:0] bank_sel;
  logic [15:0] ref_cnt;
  logic [7:0] stop_cnt;
  logic [7:0] err_cnt;
  logic [31:0] rd;
  int failures = 0;
  int check_count = 0;
  int n0;
  logic hit;

  always #12.5 ref_clk = ~ref_clk;

  sdram_ctl #(.REFRESH_BURST(BURST), .REFRESH_GAP(GAP)) sdram_ctl_i (
    .ref_clk(ref_clk), .rstn(rstn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .sdram_clk(sdram_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_sel(bank_sel), .dqm(dqm));

  sdram_dev_model sdram_dev_model_i (
    .sdram_clk(sdram_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .addr(addr), .bank_sel(bank_sel),
    .dqm(dqm), .ref_cnt(ref_cnt), .mode_reg(mode_reg),
    .stop_cnt(stop_cnt), .in_sr(in_sr), .in_pd(in_pd),
    .err_cnt(err_cnt), .out_en(out_en));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic is_true(input logic c);
    check({31'h0, c}, 32'h0000_0001);
  endtask : is_true

  task automatic sw_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
  endtask : sw_write

  task automatic sw_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    #1;
    d = sw_rdata;
  endtask : sw_read

  task automatic t_reset();
    sw_read(REG_CTRL, rd);
    check(rd, 32'h0000_0004);
    sw_read(REG_MODE, rd);
    check(rd, 32'h0000_0020);
    sw_read(8'h14, rd);
    check(rd, 32'h0000_0000);
    sw_write(REG_STATUS, 32'h0000_000F);
    sw_read(REG_STATUS, rd);
    check(rd, 32'h0000_3001);
    check({31'h0, cke}, 32'h0000_0001);
    check({31'h0, dqm}, 32'h0000_0001);
  endtask : t_reset

  task automatic t_mode_stop();
    sw_write(REG_MODE, 32'h0000_0620);
    sw_write(REG_CMD, {30'h0, SWCMD_MRS});
    for (int i = 0; i < 100 && mode_reg !== 12'h220; i++) @(posedge ref_clk);
    check({20'h0, mode_reg}, 32'h0000_0220);
    n0 = stop_cnt;
    sw_write(REG_CMD, {30'h0, SWCMD_STOP});
    for (int i = 0; i < 100 && int'(stop_cnt) == n0; i++) @(posedge ref_clk);
    is_true(int'(stop_cnt) == n0 + 1);
    check({24'h0, err_cnt}, 32'h0000_0000);
  endtask : t_mode_stop

  task automatic t_refresh();
    n0 = ref_cnt;
    repeat (20 * GAP) @(posedge ref_clk);
    is_true(int'(ref_cnt) - n0 >= 9);
    n0 = ref_cnt;
    sw_write(REG_CMD, {30'h0, SWCMD_REFBURST});
    repeat (100) @(posedge ref_clk);
    is_true(int'(ref_cnt) - n0 >= BURST);
    check({24'h0, err_cnt}, 32'h0000_0000);
    sw_read(REG_REFCNT, rd);
    check(rd, {16'h0000, ref_cnt});
  endtask : t_refresh

  task automatic t_mask();
    sw_write(REG_CTRL, 32'h0000_0000);
    for (int i = 0; i < 10 && dqm !== 1'b0; i++) @(posedge ref_clk);
    check({31'h0, dqm}, 32'h0000_0000);
    repeat (8) @(posedge ref_clk);
    check({31'h0, out_en}, 32'h0000_0001);
    sw_write(REG_CTRL, 32'h0000_0004);
    repeat (8) @(posedge ref_clk);
    check({31'h0, out_en}, 32'h0000_0000);
  endtask : t_mask

  task automatic t_powerdown();
    sw_write(REG_CTRL, 32'h0000_0005);
    for (int i = 0; i < 200 && in_pd !== 1'b1; i++) @(posedge ref_clk);
    is_true(in_pd);
    check({31'h0, cke}, 32'h0000_0000);
    n0 = ref_cnt;
    repeat (24 * GAP) @(posedge ref_clk);
    is_true(int'(ref_cnt) - n0 >= 9);
    sw_write(REG_CTRL, 32'h0000_0004);
    for (int i = 0; i < 200 && in_pd !== 1'b0; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    check({31'h0, cke}, 32'h0000_0001);
    check({24'h0, err_cnt}, 32'h0000_0000);
  endtask : t_powerdown

  task automatic t_selfref();
    n0 = ref_cnt;
    sw_write(REG_CTRL, 32'h0000_0006);
    for (int i = 0; i < 400 && in_sr !== 1'b1; i++) @(posedge ref_clk);
    is_true(in_sr);
    is_true(int'(ref_cnt) - n0 >= BURST);
    repeat (4) @(posedge ref_clk);
    hit = 1'b0;
    for (int i = 0; i < 40; i++) begin
      @(posedge ref_clk);
      hit = hit | sdram_clk | cke;
    end
    check({31'h0, hit}, 32'h0000_0000);
    sw_read(REG_STATUS, rd);
    check(rd, 32'h0000_0004);
    n0 = ref_cnt;
    sw_write(REG_CTRL, 32'h0000_0004);
    for (int i = 0; i < 200 && in_sr !== 1'b0; i++) @(posedge ref_clk);
    repeat (100) @(posedge ref_clk);
    is_true(int'(ref_cnt) - n0 >= BURST);
    check({24'h0, err_cnt}, 32'h0000_0000);
  endtask : t_selfref

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    t_reset();
    t_mode_stop();
    t_refresh();
    t_mask();
    t_powerdown();
    t_selfref();
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    give_verdict();
  end
endmodule : tb
